// File: hw/rollctr_params.svh
// constants for the secure mode and rolling counter controller
`ifndef ROLLCTR_PARAMS_SVH
`define ROLLCTR_PARAMS_SVH
`define CTR_WIDTH 24
`define CTR_RESET 24'h000000
`define TEACH_TYPE_PUSHBUTTON 4'h1
`define FACTORY_PRESSES 3'h7
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_CTR_USER 12'h008
`define REG_CTR_FACT 12'h00C
`define REG_TX_INFO 12'h010
`define REG_CUSTOM 12'h014
`define CTRL_KEY_CHANGE 0
`define CTRL_NFC_TEACH 1
`define CTRL_MODE_WE 2
`define CTRL_MODE_LSB 4
`endif

// File: hw/rollctr_pkg.sv
// types for the secure mode and rolling counter controller
package rollctr_pkg;
  typedef enum logic [1:0] {MODE_NORMAL, MODE_IMPLICIT, MODE_EXPLICIT} op_mode_t;
  typedef enum logic [1:0] {COMBO_NONE, COMBO_TWO, COMBO_THREE, COMBO_FOUR} combo_t;
  typedef enum logic [1:0] {TX_NONE, TX_DATA, TX_TEACH} tx_kind_t;
endpackage : rollctr_pkg

// File: hw/contact_if.sv
// contact classification carried between controller and decoder
`timescale 1ns/1ps
`default_nettype none
interface contact_if;
  logic [3:0] contacts;
  rollctr_pkg::combo_t combo;
  modport decoder (input contacts, output combo);
  modport user (output contacts, input combo);
endinterface : contact_if
`default_nettype wire

// File: hw/combo_decoder.sv
// classifies the four rocker contacts into a contact combination
`timescale 1ns/1ps
`default_nettype none
module combo_decoder (
  contact_if.decoder cif
);
  import rollctr_pkg::*;
  wire [2:0] count;
  wire chan_a_both;
  wire chan_b_both;
  // bits: 0 chan_a_state_zero, 1 chan_a_state_one, 2 chan_b_state_zero, 3 chan_b_state_one
  assign count = 3'(cif.contacts[0]) + 3'(cif.contacts[1]) + 3'(cif.contacts[2])
    + 3'(cif.contacts[3]);
  assign chan_a_both = cif.contacts[0] & cif.contacts[1];
  assign chan_b_both = cif.contacts[2] & cif.contacts[3];
  // a cross-channel pair is no combination; it stays a plain data press
  assign cif.combo = (count == 3'h4) ? COMBO_FOUR :
    (count == 3'h3) ? COMBO_THREE :
    ((count == 3'h2) && (chan_a_both || chan_b_both)) ? COMBO_TWO :
    COMBO_NONE;
endmodule : combo_decoder
`default_nettype wire

// File: hw/bow_sequencer.sv
// tracks the energy bow press and release sequence under a held combination
`timescale 1ns/1ps
`default_nettype none
module bow_sequencer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic bow_press,
  input wire logic bow_release,
  input wire rollctr_pkg::combo_t combo,
  output logic [3:0] presses,
  output logic [3:0] releases,
  output rollctr_pkg::combo_t held
);
  import rollctr_pkg::*;
  // a change of combination mid sequence restarts the count
  wire restart;
  assign restart = (combo != held) || (combo == COMBO_NONE);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      presses <= 4'h0;
      releases <= 4'h0;
      held <= COMBO_NONE;
    end else if (bow_press && restart) begin
      presses <= 4'h1;
      releases <= 4'h0;
      held <= combo;
    end else if (bow_press) begin
      presses <= (presses == 4'hF) ? presses : presses + 4'h1;
    end else if (bow_release && restart) begin
      presses <= 4'h0;
      releases <= 4'h0;
      held <= COMBO_NONE;
    end else if (bow_release) begin
      releases <= (releases == 4'hF) ? releases : releases + 4'h1;
    end
  end
endmodule : bow_sequencer
`default_nettype wire

// File: hw/secure_mode_rolling_counter_ctrl.sv
// operating mode, rolling counter and teach-in control of a pushbutton transmitter
`timescale 1ns/1ps
`default_nettype none
`include "rollctr_params.svh"
module secure_mode_rolling_counter_ctrl (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RSTN,
  // contacts and energy bow, one-cycle pulses for the bow
  input wire logic [3:0] CONTACTS,
  input wire logic BOW_PRESS,
  input wire logic BOW_RELEASE,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // telegram request to the encoder
  output logic TX_VALID,
  output rollctr_pkg::tx_kind_t TX_KIND,
  output logic TX_CTR_PRESENT,
  output logic [23:0] TX_CTR,
  output logic [3:0] TX_TEACH_TYPE,
  output logic TX_SINGLE,
  output logic [3:0] TX_CONTACTS,
  output rollctr_pkg::op_mode_t MODE
);
  import rollctr_pkg::*;

  // flip-flops here stand for the non-volatile store; RSTN models production only
  op_mode_t mode;
  logic [`CTR_WIDTH-1:0] ctr_user;
  logic [`CTR_WIDTH-1:0] ctr_fact;
  logic user_key;
  logic [31:0] custom_msg;
  logic [3:0] presses;
  logic [3:0] releases;
  combo_t held;
  combo_t combo;
  contact_if cif ();

  assign cif.contacts = CONTACTS;
  assign combo = cif.combo;

  combo_decoder u_dec (
    .cif(cif)
  );

  bow_sequencer u_seq (
    .clk(CORE_CLK),
    .rst_n(RSTN),
    .bow_press(BOW_PRESS),
    .bow_release(BOW_RELEASE),
    .combo(combo),
    .presses(presses),
    .releases(releases),
    .held(held)
  );

  // apb decode
  wire apb_setup;
  wire apb_wr;
  wire apb_rd;
  wire hit_ctrl;
  wire hit_status;
  wire hit_cu;
  wire hit_cf;
  wire hit_tx;
  wire hit_custom;
  wire mapped;
  assign apb_setup = PSEL && !PENABLE;
  assign hit_ctrl = PADDR == `REG_CTRL;
  assign hit_status = PADDR == `REG_STATUS;
  assign hit_cu = PADDR == `REG_CTR_USER;
  assign hit_cf = PADDR == `REG_CTR_FACT;
  assign hit_tx = PADDR == `REG_TX_INFO;
  assign hit_custom = PADDR == `REG_CUSTOM;
  assign mapped = hit_ctrl | hit_status | hit_cu | hit_cf | hit_tx | hit_custom;
  // writes take effect at the access edge, when pready is high
  assign apb_wr = PSEL && PENABLE && PREADY && PWRITE && mapped;
  assign apb_rd = apb_setup && !PWRITE;

  wire key_change;
  wire nfc_teach;
  wire sw_mode_we;
  op_mode_t sw_mode;
  assign key_change = apb_wr && hit_ctrl && PWDATA[`CTRL_KEY_CHANGE];
  assign nfc_teach = apb_wr && hit_ctrl && PWDATA[`CTRL_NFC_TEACH];
  assign sw_mode_we = apb_wr && hit_ctrl && PWDATA[`CTRL_MODE_WE];
  assign sw_mode = op_mode_t'(PWDATA[`CTRL_MODE_LSB +: 2]);
  // mode code 3 names no mode and is dropped
  wire sw_mode_ok;
  assign sw_mode_ok = sw_mode_we && (PWDATA[`CTRL_MODE_LSB +: 2] != 2'h3);

  // bow sequence events, seen on the edge they arrive
  wire seq_ok;
  wire ev_normal;
  wire ev_resend;
  wire ev_switch;
  wire ev_factory;
  wire ev_data;
  combo_t seq_combo;
  op_mode_t target;
  assign seq_combo = combo;
  assign seq_ok = (combo == held) && (combo != COMBO_NONE);
  assign target = (combo == COMBO_TWO) ? MODE_IMPLICIT : MODE_EXPLICIT;
  // four contacts: first press gives normal mode
  assign ev_normal = BOW_PRESS && (combo == COMBO_FOUR) && !seq_ok;
  // press-release with two or three contacts, only in the matching mode
  assign ev_resend = BOW_RELEASE && seq_ok && (seq_combo != COMBO_FOUR)
    && (presses == 4'h1) && (releases == 4'h0) && (mode == target);
  // second press after one release switches and teaches
  assign ev_switch = BOW_PRESS && seq_ok && (seq_combo != COMBO_FOUR)
    && (presses == 4'h1) && (releases == 4'h1);
  // seventh release with four contacts held throughout
  assign ev_factory = BOW_RELEASE && seq_ok && (seq_combo == COMBO_FOUR)
    && (presses == 4'(`FACTORY_PRESSES)) && (releases == 4'(`FACTORY_PRESSES) - 4'h1);
  // contact combinations (a same-channel pair, three or four contacts) never produce data
  assign ev_data = (BOW_PRESS || BOW_RELEASE) && (combo == COMBO_NONE);

  op_mode_t mode_after;
  wire teach;
  wire secure_after;
  wire sends;
  wire [`CTR_WIDTH-1:0] ctr_now;
  wire tx_uses_ctr;
  assign mode_after = ev_switch ? target : (ev_normal || ev_factory) ? MODE_NORMAL :
    sw_mode_ok ? sw_mode : mode;
  assign teach = ev_resend || ev_switch || (nfc_teach && mode != MODE_NORMAL);
  assign secure_after = mode_after != MODE_NORMAL;
  assign sends = teach || (ev_data && secure_after);
  assign ctr_now = user_key ? ctr_user : ctr_fact;
  assign tx_uses_ctr = teach || mode_after == MODE_EXPLICIT;

  // wrap is harmless in practice at 24 bits
  wire [`CTR_WIDTH-1:0] next_ctr;
  assign next_ctr = ctr_now + `CTR_WIDTH'(1);

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      mode <= MODE_NORMAL;
    end else begin
      mode <= mode_after;
    end
  end

  // each key keeps its own counter, so a factory reset resumes where it stopped
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      user_key <= 1'b0;
    end else if (ev_factory) begin
      user_key <= 1'b0;
    end else if (key_change) begin
      user_key <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctr_user <= `CTR_RESET;
    end else if (key_change) begin
      ctr_user <= `CTR_RESET;
    end else if (sends && user_key) begin
      ctr_user <= next_ctr;
    end
  end

  // advances even when a key change lands in the same cycle, so no value is reused
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctr_fact <= `CTR_RESET;
    end else if (sends && !user_key) begin
      ctr_fact <= next_ctr;
    end
  end

  // custom message has no reset path from the factory sequence
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      custom_msg <= 32'h00000000;
    end else if (apb_wr && hit_custom) begin
      custom_msg <= PWDATA;
    end
  end

  // telegram request, one cycle per actuation; the fields hold until the next one
  wire tx_event;
  wire tx_ctr_on;
  assign tx_event = teach || ev_data;
  assign tx_ctr_on = (teach || (ev_data && secure_after)) && tx_uses_ctr;

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      TX_VALID <= 1'b0;
    end else begin
      TX_VALID <= tx_event;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      TX_KIND <= TX_NONE;
    end else if (tx_event) begin
      TX_KIND <= teach ? TX_TEACH : TX_DATA;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      TX_CTR_PRESENT <= 1'b0;
    end else if (tx_event) begin
      TX_CTR_PRESENT <= tx_ctr_on;
    end
  end

  // value before the increment, the one the telegram is protected with
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      TX_CTR <= `CTR_RESET;
    end else if (tx_event) begin
      TX_CTR <= ctr_now;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      TX_TEACH_TYPE <= 4'h0;
    end else if (tx_event) begin
      TX_TEACH_TYPE <= teach ? `TEACH_TYPE_PUSHBUTTON : 4'h0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      TX_SINGLE <= 1'b0;
    end else if (tx_event) begin
      TX_SINGLE <= teach;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      TX_CONTACTS <= 4'h0;
    end else if (tx_event) begin
      TX_CONTACTS <= CONTACTS;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      MODE <= MODE_NORMAL;
    end else begin
      MODE <= mode_after;
    end
  end

  // apb answer: zero wait states, unmapped gives pslverr
  wire [31:0] rd_mux;
  assign rd_mux = hit_status ? {24'h000000, 2'b00, held, 1'b0, user_key, mode} :
    hit_cu ? {8'h00, ctr_user} :
    hit_cf ? {8'h00, ctr_fact} :
    hit_tx ? {8'h00, TX_CTR} :
    hit_custom ? custom_msg :
    32'h00000000;

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      PREADY <= 1'b0;
    end else begin
      PREADY <= apb_setup;
    end
  end

  // unmapped addresses answer with an error and are never written
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      PSLVERR <= 1'b0;
    end else begin
      PSLVERR <= apb_setup && !mapped;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      PRDATA <= 32'h00000000;
    end else begin
      PRDATA <= apb_rd ? rd_mux : 32'h00000000;
    end
  end
endmodule : secure_mode_rolling_counter_ctrl
`default_nettype wire

// File: bench/secure_ctrl_chk.sv
// assertions on the mode and rolling counter controller ports
`timescale 1ns/1ps
`default_nettype none
module secure_ctrl_chk (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RSTN,
  // contacts, bow and bus select
  input wire logic [3:0] CONTACTS,
  input wire logic BOW_PRESS,
  input wire logic BOW_RELEASE,
  input wire logic PSEL,
  // telegram request
  input wire logic TX_VALID,
  input wire rollctr_pkg::tx_kind_t TX_KIND,
  input wire logic TX_CTR_PRESENT,
  input wire logic [3:0] TX_TEACH_TYPE,
  input wire logic TX_SINGLE,
  input wire rollctr_pkg::op_mode_t MODE
);
  import rollctr_pkg::*;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  wire logic three = $countones(CONTACTS) == 3;
  // cross-channel pairs are plain presses
  wire logic combo = three || CONTACTS == 4'hF || CONTACTS == 4'h3 || CONTACTS == 4'hC;
  sequence teach_s;
    TX_VALID && TX_KIND == TX_TEACH;
  endsequence
  sequence data_s;
    TX_VALID && TX_KIND == TX_DATA;
  endsequence
  type_code_a: assert property (teach_s |-> TX_TEACH_TYPE == 4'h1)
    else $error("teach-in type code wrong");
  single_teach_a: assert property (teach_s |-> TX_SINGLE)
    else $error("teach-in not single");
  teach_ctr_a: assert property (teach_s |-> TX_CTR_PRESENT)
    else $error("teach-in without counter");
  teach_mode_a: assert property (teach_s |-> MODE != MODE_NORMAL)
    else $error("teach-in in normal mode");
  explicit_ctr_a: assert property (data_s and MODE == MODE_EXPLICIT |-> TX_CTR_PRESENT)
    else $error("explicit data without counter");
  implicit_ctr_a: assert property (data_s and MODE != MODE_EXPLICIT |-> !TX_CTR_PRESENT)
    else $error("counter in non-explicit data");
  combo_quiet_a: assert property ((BOW_PRESS || BOW_RELEASE) && combo |=> !TX_VALID || TX_KIND != TX_DATA)
    else $error("data telegram on combination");
  four_normal_a: assert property (BOW_PRESS && CONTACTS == 4'hF |=> MODE == MODE_NORMAL)
    else $error("four contacts did not select normal");
  explicit_cause_a: assert property ($changed(MODE) && MODE == MODE_EXPLICIT |->
    $past(PSEL) || $past(BOW_PRESS) && $past(three))
    else $error("explicit mode without three contacts");
endmodule : secure_ctrl_chk
bind secure_mode_rolling_counter_ctrl secure_ctrl_chk chk (.CORE_CLK(CORE_CLK), .RSTN(RSTN),
  .CONTACTS(CONTACTS), .BOW_PRESS(BOW_PRESS), .BOW_RELEASE(BOW_RELEASE), .PSEL(PSEL),
  .TX_VALID(TX_VALID), .TX_KIND(TX_KIND), .TX_CTR_PRESENT(TX_CTR_PRESENT),
  .TX_TEACH_TYPE(TX_TEACH_TYPE), .TX_SINGLE(TX_SINGLE), .MODE(MODE));
`default_nettype wire

// File: bench/rx_model.sv
// receiver that tracks the transmitter's rolling counter
`timescale 1ns/1ps
`default_nettype none
module rx_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // received telegrams
  input wire logic tx_valid,
  input wire rollctr_pkg::tx_kind_t tx_kind,
  input wire logic tx_ctr_present,
  input wire logic [23:0] tx_ctr,
  // next expected counter
  output logic [23:0] rx_ctr
);
  import rollctr_pkg::*;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_ctr <= 24'h000000;
    end else if (tx_valid && (tx_kind == TX_TEACH || tx_ctr_present && tx_ctr >= rx_ctr)) begin
      rx_ctr <= tx_ctr + 24'h000001;
    end else if (tx_valid && tx_kind == TX_DATA && !tx_ctr_present) begin
      rx_ctr <= rx_ctr + 24'h000001;
    end
  end
endmodule : rx_model
`default_nettype wire

// File: bench/testbench.sv
// self-checking bench for the mode and rolling counter controller
`timescale 1ns/1ps
`default_nettype none
`include "rollctr_params.svh"
module testbench;
  import rollctr_pkg::*;
  logic CORE_CLK = 1'b0, RSTN = 1'b0, BOW_PRESS = 1'b0, BOW_RELEASE = 1'b0;
  logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, PREADY, PSLVERR, er;
  logic [3:0] CONTACTS = 4'h0, TX_TEACH_TYPE, TX_CONTACTS;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h00000000, PRDATA, rd, cust, seed = 32'h0000B0BD;
  logic TX_VALID, TX_CTR_PRESENT, TX_SINGLE;
  logic [23:0] TX_CTR, rx_ctr;
  tx_kind_t TX_KIND;
  op_mode_t MODE;
  logic [28:0] q[$];
  int errors = 0, checked = 0;
  always #5 CORE_CLK = ~CORE_CLK;
  secure_mode_rolling_counter_ctrl dut (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .CONTACTS(CONTACTS),
    .BOW_PRESS(BOW_PRESS), .BOW_RELEASE(BOW_RELEASE), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .TX_VALID(TX_VALID), .TX_KIND(TX_KIND), .TX_CTR_PRESENT(TX_CTR_PRESENT),
    .TX_CTR(TX_CTR), .TX_TEACH_TYPE(TX_TEACH_TYPE), .TX_SINGLE(TX_SINGLE),
    .TX_CONTACTS(TX_CONTACTS), .MODE(MODE));
  rx_model rx (.clk(CORE_CLK), .rst_n(RSTN), .tx_valid(TX_VALID), .tx_kind(TX_KIND),
    .tx_ctr_present(TX_CTR_PRESENT), .tx_ctr(TX_CTR), .rx_ctr(rx_ctr));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic print_verdict;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t reg got %h exp %h", $time, got, exp);
    end
  endtask : cmp_reg
  task automatic cmp_tx(input logic [28:0] got, input logic [28:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t tx got %h exp %h", $time, got, exp);
    end
  endtask : cmp_tx
  task automatic note(input op_mode_t m, input tx_kind_t k, input logic p, input logic [23:0] c);
    q.push_back({m, k, p, c});
  endtask : note
  // telegram watcher: every request takes the oldest note
  always @(posedge CORE_CLK) begin
    if (TX_VALID === 1'b1) begin
      cmp_tx({MODE, TX_KIND, TX_CTR_PRESENT, (TX_CTR_PRESENT | TX_KIND == TX_TEACH) ? TX_CTR :
        24'h000000}, q.size() > 0 ? q.pop_front() : 29'h1FFFFFFF);
      cmp_reg({28'h0000000, TX_CONTACTS}, {28'h0000000, CONTACTS});
    end
  end
  task automatic bow(input logic p, input logic [3:0] c);
    CONTACTS <= c;
    BOW_PRESS <= p;
    BOW_RELEASE <= !p;
    @(posedge CORE_CLK);
    BOW_PRESS <= 1'b0;
    BOW_RELEASE <= 1'b0;
    repeat (3) @(posedge CORE_CLK);
  endtask : bow
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 16);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    rd = PRDATA;
    er = PSLVERR;
    if (PREADY !== 1'b1) begin
      errors++;
      print_verdict();
    end else begin
      @(posedge CORE_CLK);
    end
  endtask : apb
  // slave error folded into bit 31
  task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    cmp_reg((rd & m) | {er, 31'h0}, e);
  endtask : rchk
  initial begin
    #900000;
    errors++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge CORE_CLK);
    RSTN <= 1'b1;
    @(posedge CORE_CLK);
    rchk(`REG_STATUS, 32'h00000007, 32'h00000000);
    rchk(`REG_CTR_FACT, 32'h00FFFFFF, 32'h00000000);
    rchk(12'h018, 32'hFFFFFFFF, 32'h80000000);
    seed = xs(seed);
    cust = seed;
    apb(1'b1, `REG_CUSTOM, cust);
    note(MODE_NORMAL, TX_DATA, 1'b0, 24'h0);
    bow(1'b1, 4'h1 << seed[1:0]);
    bow(1'b1, 4'h7);
    bow(1'b0, 4'h7);
    note(MODE_EXPLICIT, TX_TEACH, 1'b1, 24'h0);
    bow(1'b1, 4'h7);
    note(MODE_EXPLICIT, TX_DATA, 1'b1, 24'h1);
    bow(1'b0, 4'h2);
    note(MODE_EXPLICIT, TX_DATA, 1'b1, 24'h2);
    bow(1'b1, 4'h8);
    cmp_reg({8'h00, rx_ctr}, 32'h00000003);
    seed = xs(seed);
    bow(1'b1, ~(4'h1 << seed[1:0]));
    note(MODE_EXPLICIT, TX_TEACH, 1'b1, 24'h3);
    bow(1'b0, ~(4'h1 << seed[1:0]));
    note(MODE_EXPLICIT, TX_TEACH, 1'b1, 24'h4);
    apb(1'b1, `REG_CTRL, 32'h00000002);
    bow(1'b1, 4'h3);
    bow(1'b0, 4'h3);
    note(MODE_IMPLICIT, TX_TEACH, 1'b1, 24'h5);
    bow(1'b1, 4'h3);
    note(MODE_IMPLICIT, TX_DATA, 1'b0, 24'h0);
    bow(1'b0, 4'h1);
    seed = xs(seed);
    note(MODE_IMPLICIT, TX_DATA, 1'b0, 24'h0);
    bow(1'b1, {seed[0], ~seed[0], seed[0], ~seed[0]});
    cmp_reg({8'h00, rx_ctr}, 32'h00000008);
    apb(1'b1, `REG_CTRL, 32'h00000001);
    rchk(`REG_CTR_USER, 32'h00FFFFFF, 32'h00000000);
    bow(1'b1, 4'hC);
    note(MODE_IMPLICIT, TX_TEACH, 1'b1, 24'h0);
    bow(1'b0, 4'hC);
    for (int i = 0; i < 7; i++) begin
      bow(1'b1, 4'hF);
      bow(1'b0, 4'hF);
    end
    rchk(`REG_STATUS, 32'h00000007, 32'h00000000);
    rchk(`REG_CTR_FACT, 32'h00FFFFFF, 32'h00000008);
    rchk(`REG_CUSTOM, 32'h7FFFFFFF, cust & 32'h7FFFFFFF);
    apb(1'b1, `REG_CTRL, 32'h00000014);
    rchk(`REG_STATUS, 32'h00000003, 32'h00000001);
    apb(1'b1, `REG_CTRL, 32'h00000034);
    rchk(`REG_STATUS, 32'h00000003, 32'h00000001);
    bow(1'b1, 4'hE);
    bow(1'b0, 4'hE);
    note(MODE_EXPLICIT, TX_TEACH, 1'b1, 24'h8);
    bow(1'b1, 4'hE);
    rchk(`REG_TX_INFO, 32'h00FFFFFF, 32'h00000008);
    cmp_reg({8'h00, rx_ctr}, 32'h00000009);
    cmp_reg(q.size(), 32'h00000000);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
